/* File: verilog/dsg_defs.vh */
// register map, field positions and reset values for the deep-sleep gate / soft reset block
// assumes a 32-bit avalon-mm slave with byte addressing on a word-aligned address bus
`ifndef DSG_DEFS_VH
`define DSG_DEFS_VH

`define DSG_AW 12
`define DSG_DW 32
`define DSG_OFF_SOFT_RESET0 12'h040
`define DSG_OFF_RUN_GATE2 12'h100
`define DSG_OFF_SLEEP_GATE2 12'h118
`define DSG_OFF_DEEP_GATE2 12'h128
`define DSG_OFF_RUN_CFG 12'h060
`define DSG_OFF_MODE 12'h180
`define DSG_OFF_CAPMASK1 12'h184
`define DSG_OFF_IRQ_STATUS 12'h188
`define DSG_OFF_IRQ_MASK 12'h18C
`define DSG_OFF_FAULT_UNIT 12'h190

// implemented gate bits: dma engine at 13, ports e..a at 4..0
`define DSG_GATE_MASK 32'h0000201F
`define DSG_GATE_W 6
// implemented reset bits: can_unit_zero_reset 24, pwm 20, adc0 16, hib 6, wdt 3
`define DSG_RST_MASK 32'h01110048
`define DSG_RST_CAN 24
`define DSG_RST_PWM 20
`define DSG_RST_ADC 16
`define DSG_RST_HIB 6
`define DSG_RST_WDT 3
`define DSG_DMA_BIT 13
`define DSG_ACG_BIT 27
`define DSG_RUN_CFG_MASK 32'h08000000
`define DSG_CAPMASK1_RESET 32'h01110048
`define DSG_ZERO 32'h00000000

// power modes
`define DSG_MODE_W 2
`define DSG_MODE_RUN 2'h0
`define DSG_MODE_SLEEP 2'h1
`define DSG_MODE_DEEP 2'h2

// interrupt events: bit 0 gated-unit access fault, bit 1 soft reset asserted
`define DSG_IRQ_W 2
`define DSG_IRQ_FAULT 0
`define DSG_IRQ_RST 1
`define DSG_IRQ_MASK_ALL 2'h3

`endif

/* File: verilog/dsg_top.v */
// deep-sleep clock gate group 2, mode-based gate select, and soft reset group 0
// assumes one 20 MHz clock; unit accesses are reported on UNIT_REQ with a unit index
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "dsg_defs.vh"

module dsg_top (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire [`DSG_AW-1:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [`DSG_DW-1:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [`DSG_DW-1:0] AVS_READDATA,
  output reg [1:0] AVS_RESPONSE,
  output reg AVS_WAITREQUEST,
  input wire UNIT_REQ,
  input wire [2:0] UNIT_SEL,
  output reg UNIT_FAULT,
  output reg UNIT_ACK,
  output reg [`DSG_GATE_W-1:0] UNIT_CLK_EN,
  output reg CAN_UNIT_ZERO_RESET_RESET,
  output reg PWM_RESET,
  output reg ADC0_RESET,
  output reg HIB_RESET,
  output reg WDT_RESET,
  output reg IRQ
);

  // unit index on UNIT_SEL: 0..4 ports a..e, 5 dma engine
  localparam [2:0] SEL_DMA = 3'h5;
  localparam [1:0] RESP_OK = 2'h0;
  localparam [1:0] RESP_SLVERR = 2'h2;
  localparam [1:0] RESP_DECERR = 2'h3;

  reg [`DSG_DW-1:0] run_gate_q;
  reg [`DSG_DW-1:0] sleep_gate_q;
  reg [`DSG_DW-1:0] deep_gate_q;
  reg [`DSG_DW-1:0] run_cfg_q;
  reg [`DSG_DW-1:0] soft_rst_q;
  reg [`DSG_DW-1:0] capmask_q;
  reg [`DSG_MODE_W-1:0] mode_q;
  reg [`DSG_IRQ_W-1:0] irq_stat_q;
  reg [`DSG_IRQ_W-1:0] irq_mask_q;
  reg [2:0] fault_unit_q;
  reg done_q;

  reg [`DSG_DW-1:0] active_gate;
  reg [`DSG_GATE_W-1:0] clk_en_d;
  reg [`DSG_DW-1:0] rdata_d;
  reg hit;
  reg [`DSG_IRQ_W-1:0] irq_stat_d;
  reg unit_on;

  wire acc = (AVS_READ | AVS_WRITE) & ~done_q;
  wire wr = AVS_WRITE & ~done_q;
  wire [`DSG_DW-1:0] wdata_ok;

  // byte-enable merge; mask keeps reserved bits at zero
  function [`DSG_DW-1:0] merge;
    input [`DSG_DW-1:0] old;
    input [`DSG_DW-1:0] nw;
    input [3:0] be;
    input [`DSG_DW-1:0] msk;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
      merge = merge & msk;
    end
  endfunction

  // compress a gate register into the six unit enables
  function [`DSG_GATE_W-1:0] pick;
    input [`DSG_DW-1:0] g;
    begin
      pick = {g[`DSG_DMA_BIT], g[4:0]};
    end
  endfunction

  assign wdata_ok = AVS_WRITEDATA;

  always @* begin
    // auto gating off: run gates apply in every mode
    if (!run_cfg_q[`DSG_ACG_BIT]) begin
      active_gate = run_gate_q;
    end else begin
      case (mode_q)
        `DSG_MODE_SLEEP: active_gate = sleep_gate_q;
        `DSG_MODE_DEEP: active_gate = deep_gate_q;
        default: active_gate = run_gate_q;
      endcase
    end
    clk_en_d = pick(active_gate);
  end

  always @* begin
    hit = 1'b1;
    rdata_d = `DSG_ZERO;
    case (AVS_ADDRESS)
      `DSG_OFF_SOFT_RESET0: rdata_d = soft_rst_q;
      `DSG_OFF_RUN_GATE2: rdata_d = run_gate_q;
      `DSG_OFF_SLEEP_GATE2: rdata_d = sleep_gate_q;
      `DSG_OFF_DEEP_GATE2: rdata_d = deep_gate_q;
      `DSG_OFF_RUN_CFG: rdata_d = run_cfg_q;
      `DSG_OFF_MODE: rdata_d = {{(`DSG_DW-`DSG_MODE_W){1'b0}}, mode_q};
      `DSG_OFF_CAPMASK1: rdata_d = capmask_q;
      `DSG_OFF_IRQ_STATUS: rdata_d = {{(`DSG_DW-`DSG_IRQ_W){1'b0}}, irq_stat_q};
      `DSG_OFF_IRQ_MASK: rdata_d = {{(`DSG_DW-`DSG_IRQ_W){1'b0}}, irq_mask_q};
      `DSG_OFF_FAULT_UNIT: rdata_d = {29'h0000000, fault_unit_q};
      default: hit = 1'b0;
    endcase
  end

  // enable of the unit addressed by UNIT_SEL, judged on the registered enables
  always @* begin
    if (UNIT_SEL == SEL_DMA) begin
      unit_on = UNIT_CLK_EN[`DSG_GATE_W-1];
    end else if (UNIT_SEL < SEL_DMA) begin
      unit_on = UNIT_CLK_EN[UNIT_SEL];
    end else begin
      unit_on = 1'b0;
    end
  end

  always @* begin
    irq_stat_d = irq_stat_q;
    if (wr && AVS_ADDRESS == `DSG_OFF_IRQ_STATUS && AVS_BYTEENABLE[0]) begin
      irq_stat_d = irq_stat_q & ~AVS_WRITEDATA[`DSG_IRQ_W-1:0];
    end
    // set after clear so a same-cycle event is kept
    if (UNIT_REQ && !unit_on) begin
      irq_stat_d[`DSG_IRQ_FAULT] = 1'b1;
    end
    if (wr && AVS_ADDRESS == `DSG_OFF_SOFT_RESET0 &&
        |(merge(soft_rst_q, wdata_ok, AVS_BYTEENABLE, capmask_q & `DSG_RST_MASK) &
          ~soft_rst_q)) begin
      irq_stat_d[`DSG_IRQ_RST] = 1'b1;
    end
  end

  always @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      run_gate_q <= `DSG_ZERO;
      sleep_gate_q <= `DSG_ZERO;
      deep_gate_q <= `DSG_ZERO;
      run_cfg_q <= `DSG_ZERO;
      soft_rst_q <= `DSG_ZERO;
      capmask_q <= `DSG_CAPMASK1_RESET;
      mode_q <= `DSG_MODE_RUN;
      irq_stat_q <= {`DSG_IRQ_W{1'b0}};
      irq_mask_q <= {`DSG_IRQ_W{1'b0}};
      fault_unit_q <= 3'h0;
      done_q <= 1'b0;
      AVS_READDATA <= `DSG_ZERO;
      AVS_RESPONSE <= RESP_OK;
      AVS_WAITREQUEST <= 1'b1;
      UNIT_FAULT <= 1'b0;
      UNIT_ACK <= 1'b0;
      UNIT_CLK_EN <= {`DSG_GATE_W{1'b0}};
      CAN_UNIT_ZERO_RESET_RESET <= 1'b0;
      PWM_RESET <= 1'b0;
      ADC0_RESET <= 1'b0;
      HIB_RESET <= 1'b0;
      WDT_RESET <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      // one wait cycle: request seen, answer registered, then released
      done_q <= acc;
      AVS_WAITREQUEST <= ~acc;
      AVS_READDATA <= (acc && AVS_READ && hit) ? rdata_d : `DSG_ZERO;
      AVS_RESPONSE <= (acc && !hit) ? RESP_DECERR : RESP_OK;
      if (wr) begin
        case (AVS_ADDRESS)
          `DSG_OFF_SOFT_RESET0:
            soft_rst_q <= merge(soft_rst_q, wdata_ok, AVS_BYTEENABLE,
                                capmask_q & `DSG_RST_MASK);
          `DSG_OFF_RUN_GATE2:
            run_gate_q <= merge(run_gate_q, wdata_ok, AVS_BYTEENABLE, `DSG_GATE_MASK);
          `DSG_OFF_SLEEP_GATE2:
            sleep_gate_q <= merge(sleep_gate_q, wdata_ok, AVS_BYTEENABLE, `DSG_GATE_MASK);
          `DSG_OFF_DEEP_GATE2:
            deep_gate_q <= merge(deep_gate_q, wdata_ok, AVS_BYTEENABLE,
                                 `DSG_GATE_MASK);
          `DSG_OFF_RUN_CFG:
            run_cfg_q <= merge(run_cfg_q, wdata_ok, AVS_BYTEENABLE, `DSG_RUN_CFG_MASK);
          `DSG_OFF_MODE:
            if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[`DSG_MODE_W-1:0] != 2'h3) begin
              mode_q <= AVS_WRITEDATA[`DSG_MODE_W-1:0];
            end
          `DSG_OFF_CAPMASK1:
            capmask_q <= merge(capmask_q, wdata_ok, AVS_BYTEENABLE, `DSG_RST_MASK);
          `DSG_OFF_IRQ_MASK:
            if (AVS_BYTEENABLE[0]) begin
              irq_mask_q <= AVS_WRITEDATA[`DSG_IRQ_W-1:0];
            end
          default: ;
        endcase
      end
      irq_stat_q <= irq_stat_d;
      IRQ <= |(irq_stat_d & irq_mask_q);
      UNIT_CLK_EN <= clk_en_d;
      // unit access answers: fault when its clock is stopped
      UNIT_ACK <= UNIT_REQ & unit_on;
      UNIT_FAULT <= UNIT_REQ & ~unit_on;
      if (UNIT_REQ && !unit_on) begin
        fault_unit_q <= UNIT_SEL;
      end
      // reset outputs follow the register level; clearing releases
      CAN_UNIT_ZERO_RESET_RESET <= soft_rst_q[`DSG_RST_CAN];
      PWM_RESET <= soft_rst_q[`DSG_RST_PWM];
      ADC0_RESET <= soft_rst_q[`DSG_RST_ADC];
      HIB_RESET <= soft_rst_q[`DSG_RST_HIB];
      WDT_RESET <= soft_rst_q[`DSG_RST_WDT];
    end
  end

endmodule

/* File: dv/dsg_top_sva.sv */
// checker for the gate and soft reset block: bus wait, unit answers, reset values
// assumes it is bound to dsg_top and sees only that module's ports
`timescale 1ns/1ns
module dsg_top_chk (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire AVS_WAITREQUEST,
  input wire UNIT_REQ,
  input wire [2:0] UNIT_SEL,
  input wire UNIT_ACK,
  input wire UNIT_FAULT,
  input wire [5:0] UNIT_CLK_EN,
  input wire CAN_UNIT_ZERO_RESET_RESET,
  input wire PWM_RESET,
  input wire ADC0_RESET,
  input wire HIB_RESET,
  input wire WDT_RESET,
  input wire IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // gate enables and unit reset outputs may only move one edge after a completed write
  reg wr_done_q;
  always @(posedge SYS_CLK) wr_done_q <= RESET_N && AVS_WRITE && !AVS_WAITREQUEST;
  sequence s_taken;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && $past(AVS_WAITREQUEST);
  endsequence
  sequence s_gated;
    UNIT_REQ && UNIT_SEL < 3'h6 && !UNIT_CLK_EN[UNIT_SEL];
  endsequence
  a_wait_one: assert property (s_taken |=> !AVS_WAITREQUEST) else $error("no answer");
  a_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long answer");
  a_gated_fault: assert property (s_gated |=> UNIT_FAULT && !UNIT_ACK)
    else $error("gated unit not faulted");
  a_clocked_ack: assert property (UNIT_REQ && UNIT_SEL < 3'h6 && UNIT_CLK_EN[UNIT_SEL]
    |=> UNIT_ACK && !UNIT_FAULT) else $error("clocked unit not served");
  a_no_unit: assert property (UNIT_REQ && UNIT_SEL > 3'h5 |=> UNIT_FAULT)
    else $error("absent unit not faulted");
  a_no_request: assert property (!UNIT_REQ |=> !UNIT_ACK && !UNIT_FAULT)
    else $error("answer without request");
  a_reset_clear: assert property ($rose(RESET_N) |-> UNIT_CLK_EN == 6'h00 && !IRQ
    && !(CAN_UNIT_ZERO_RESET_RESET || PWM_RESET || ADC0_RESET || HIB_RESET || WDT_RESET)) else $error("reset");
  a_gate_moves: assert property ($changed(UNIT_CLK_EN) |-> wr_done_q)
    else $error("gate moved alone");
  a_unit_reset: assert property ($changed({CAN_UNIT_ZERO_RESET_RESET, PWM_RESET, ADC0_RESET, HIB_RESET,
    WDT_RESET}) |-> wr_done_q) else $error("unit reset moved alone");
endmodule
bind dsg_top dsg_top_chk u_dsg_top_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .UNIT_REQ(UNIT_REQ), .UNIT_SEL(UNIT_SEL), .UNIT_ACK(UNIT_ACK), .UNIT_FAULT(UNIT_FAULT),
  .UNIT_CLK_EN(UNIT_CLK_EN), .CAN_UNIT_ZERO_RESET_RESET(CAN_UNIT_ZERO_RESET_RESET), .PWM_RESET(PWM_RESET),
  .ADC0_RESET(ADC0_RESET), .HIB_RESET(HIB_RESET), .WDT_RESET(WDT_RESET), .IRQ(IRQ));

/* File: dv/deep_sleep_gate_and_soft_reset_bench.sv */
// self-checking bench for dsg_top: registers, mode gating, unit access, interrupt
// assumes the design's defines header and a 20 MHz clock
`timescale 1ns/1ns
`include "dsg_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module deep_sleep_gate_and_soft_reset_bench;
  logic SYS_CLK = 0, RESET_N = 0, AVS_READ = 0, AVS_WRITE = 0, UNIT_REQ = 0;
  logic [11:0] AVS_ADDRESS = 0;
  logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, seed = 32'h94BE, q, x, g[3];
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [2:0] UNIT_SEL = 0;
  logic [1:0] AVS_RESPONSE, r;
  logic [5:0] UNIT_CLK_EN;
  logic [7:0] e6;
  logic AVS_WAITREQUEST, UNIT_FAULT, UNIT_ACK, CAN_UNIT_ZERO_RESET_RESET, PWM_RESET, ADC0_RESET;
  logic HIB_RESET, WDT_RESET, IRQ;
  logic [4:0] rst_out;
  assign rst_out = {CAN_UNIT_ZERO_RESET_RESET, PWM_RESET, ADC0_RESET, HIB_RESET, WDT_RESET};
  int bad_count = 0, tests_run = 0;
  dsg_top u_dsg_top (.SYS_CLK, .RESET_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_BYTEENABLE, .AVS_READDATA, .AVS_RESPONSE, .AVS_WAITREQUEST, .UNIT_REQ, .UNIT_SEL,
    .UNIT_FAULT, .UNIT_ACK, .UNIT_CLK_EN, .CAN_UNIT_ZERO_RESET_RESET, .PWM_RESET, .ADC0_RESET, .HIB_RESET,
    .WDT_RESET, .IRQ);
  initial forever #25 SYS_CLK = ~SYS_CLK;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] en6(input logic [31:0] v);
    return {2'b00, v[13], v[4:0]};
  endfunction
  // unit reset outputs in port order: can 24, pwm 20, adc 16, hib 6, wdt 3
  function automatic logic [4:0] rst5(input logic [31:0] v);
    return {v[24], v[20], v[16], v[6], v[3]};
  endfunction
  task complete_run();
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // a new call always lets one edge pass, so release and raise never share a step
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do begin @(posedge SYS_CLK); n++; end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    q = AVS_READDATA;
    r = AVS_RESPONSE;
    AVS_WRITE <= 0;
    AVS_READ <= 0;
    if (n >= 20) begin bad_count++; complete_run(); end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1, a, d);
    #1;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] v);
    bus(0, a, 0);
    `CHK(q, v)
    `CHK(r, 2'b00)
  endtask
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RESET_N <= 1;
    rd(`DSG_OFF_SOFT_RESET0, 0);
    rd(`DSG_OFF_DEEP_GATE2, 0);
    `CHK(UNIT_CLK_EN, 6'h00)
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      if (i == 4) wr(`DSG_OFF_CAPMASK1, 32'h01000008);
      x = rnd();
      wr(`DSG_OFF_SOFT_RESET0, x);
      x = x & `DSG_RST_MASK & (i < 4 ? `DSG_RST_MASK : 32'h01000008);
      rd(`DSG_OFF_SOFT_RESET0, x);
      `CHK(rst_out, rst5(x))
    end
    wr(`DSG_OFF_SOFT_RESET0, 0);
    wr(`DSG_OFF_IRQ_MASK, 2);
    wr(`DSG_OFF_IRQ_STATUS, 3);
    `CHK(IRQ, 1'b0)
    wr(`DSG_OFF_SOFT_RESET0, 8);
    `CHK({IRQ, WDT_RESET}, 2'b11)
    wr(`DSG_OFF_IRQ_MASK, 0);
    `CHK(IRQ, 1'b0)
    wr(`DSG_OFF_IRQ_MASK, 2);
    `CHK(IRQ, 1'b1)
    wr(`DSG_OFF_IRQ_STATUS, 2);
    `CHK(IRQ, 1'b0)
    $display("test soft reset done");
    for (int j = 0; j < 3; j++) g[j] = rnd();
    wr(`DSG_OFF_RUN_GATE2, g[0]);
    wr(`DSG_OFF_SLEEP_GATE2, g[1]);
    wr(`DSG_OFF_DEEP_GATE2, g[2]);
    rd(`DSG_OFF_DEEP_GATE2, g[2] & `DSG_GATE_MASK);
    for (int m = 0; m < 3; m++) for (int a = 0; a < 2; a++) begin
      wr(`DSG_OFF_RUN_CFG, a ? `DSG_RUN_CFG_MASK : 0);
      wr(`DSG_OFF_MODE, m);
      `CHK(UNIT_CLK_EN, en6(g[a ? m : 0]))
    end
    // mode code 3 is not a mode; the deep-sleep selection must stay
    wr(`DSG_OFF_MODE, 3);
    rd(`DSG_OFF_MODE, 2);
    $display("test gating done");
    e6 = en6(g[2]);
    for (int s = 0; s < 8; s++) begin
      @(posedge SYS_CLK);
      UNIT_REQ <= 1;
      UNIT_SEL <= s;
      @(posedge SYS_CLK);
      UNIT_REQ <= 0;
      #1;
      `CHK({UNIT_FAULT, UNIT_ACK}, (s < 6 && e6[s]) ? 2'b01 : 2'b10)
    end
    rd(`DSG_OFF_IRQ_STATUS, 32'h1);
    rd(`DSG_OFF_FAULT_UNIT, 32'h7);
    bus(0, 12'h004, 0);
    `CHK({r, q}, {2'h3, 32'h0})
    $display("test unit access done");
    complete_run();
  end
endmodule
